/* logic/tpsp_regs.svh */
`ifndef TPSP_REGS_SVH
`define TPSP_REGS_SVH
// Operation
// - Three sine references 120 degrees apart, pure or with third harmonic.
// - Each update advances the wave pointer by the table increment.
// - Table holds one quadrant; others come by mirrored index and negated sign.
// - Stored samples span zero to half the PWM modulus.
// - Phases A, B, C go to the first, third and fifth drive outputs.
// - Duty values refresh once every N PWM periods, N from the prescaler.
// - Overcurrent rising edge kills all six outputs, sets fault and overcurrent flags.
// - Bus voltage above 400 V while braking kills outputs, sets fault and overvoltage flags.
// - Overvoltage faults only while braking; when motoring it just disables PFC.
// - Overvoltage fault detection is masked while the PFC runs.
// - Fault holds until switch goes stop then start, or host clear bit.
// - After clearing, the motor restarts once the switch is at start.
// - During fault recovery the drive stays off until the recovery timer expires.
// - Fault indicator flashes while overcurrent or overvoltage fault is active.
// - Overvoltage while decelerating holds the speed ramp until the bus discharges.
// - Motor speed period is counted between successive tachometer rising edges.
// - PFC enable output follows the drive state, but is off while braking or on bus overvoltage.
// - Fault indicator toggles so that it flashes at 0.5 Hz.

// Timing
`define TPSP_CLK_HZ 64'd25000000
`define TPSP_PWM_HZ 64'd16000
`define TPSP_MODULUS_RST 12'((`TPSP_CLK_HZ) / (`TPSP_PWM_HZ))
`define TPSP_LED_FLASH_MHZ 64'd500
`define TPSP_LED_TOGGLE_CYC ((`TPSP_CLK_HZ * 64'd1000) / (64'd2 * `TPSP_LED_FLASH_MHZ))
`define TPSP_RECOVERY_MS 64'd500
`define TPSP_RECOVERY_CYC ((`TPSP_CLK_HZ * `TPSP_RECOVERY_MS) / 64'd1000)

// Wave phase offsets
`define TPSP_PHASE_A_OFS 16'h0000
`define TPSP_PHASE_B_OFS 16'h5555
`define TPSP_PHASE_C_OFS 16'haaab

// Register byte addresses
`define TPSP_ADDR_CTRL 8'h00
`define TPSP_ADDR_INC 8'h04
`define TPSP_ADDR_AMP 8'h08
`define TPSP_ADDR_PRESC 8'h0c
`define TPSP_ADDR_MOD 8'h10
`define TPSP_ADDR_OVLIM 8'h14
`define TPSP_ADDR_STATUS 8'h18
`define TPSP_ADDR_TACHO 8'h1c
`define TPSP_ADDR_DUTY_A 8'h20
`define TPSP_ADDR_DUTY_B 8'h24
`define TPSP_ADDR_DUTY_C 8'h28

// Fields
`define TPSP_CTRL_THIRD 0
`define TPSP_CTRL_ERRCLR 1
`define TPSP_ST_GF 0
`define TPSP_ST_OC 1
`define TPSP_ST_OV 2
`define TPSP_ST_RUN 3
`define TPSP_ST_PFC 4
`define TPSP_ST_HOLD 5

// Reset values
`define TPSP_INC_RST 16'h0000
`define TPSP_AMP_RST 8'h00
`define TPSP_PRESC_RST 3'h4
`define TPSP_OVLIM_RST 10'h190
`define TPSP_OV_HYST 10'h014

// AXI responses
`define TPSP_RESP_OKAY 2'h0
`define TPSP_RESP_SLVERR 2'h2
`endif

/* logic/tpsp_pkg.sv */
package tpsp_pkg;
  typedef enum logic [1:0] {
    TPSP_STOP,
    TPSP_RUN,
    TPSP_FAULT,
    TPSP_RECOVER
  } tpsp_state_t;
endpackage

/* logic/tpsp_wave_if.sv */
`timescale 1ns/1ps
interface tpsp_wave_if;
  logic [15:0] phase_acc;
  logic third_harm;
  logic [7:0] amplitude;
  logic [11:0] half_mod;
  logic [11:0] duty [3];
  modport ctrl (output phase_acc, output third_harm, output amplitude, output half_mod, input duty);
  modport wave (input phase_acc, input third_harm, input amplitude, input half_mod, output duty);
endinterface

/* logic/tpsp_wave.sv */
`timescale 1ns/1ps
`include "tpsp_regs.svh"
module tpsp_wave (
  tpsp_wave_if.wave wif
);
  // Quarter wave, 255 = half modulus
  localparam logic [7:0] SINE_TBL [16] = '{8'h0d, 8'h25, 8'h3e, 8'h56, 8'h6d, 8'h83, 8'h98, 8'hab,
                                           8'hbd, 8'hcd, 8'hdb, 8'he7, 8'hf0, 8'hf7, 8'hfc, 8'hff};
  localparam logic [7:0] THIRD_TBL [16] = '{8'h16, 8'h40, 8'h68, 8'h8d, 8'had, 8'hc8, 8'hde, 8'hed,
                                            8'hf7, 8'hfd, 8'hff, 8'hfe, 8'hfc, 8'hf9, 8'hf7, 8'hf6};
  localparam logic [15:0] OFS [3] = '{`TPSP_PHASE_A_OFS, `TPSP_PHASE_B_OFS, `TPSP_PHASE_C_OFS};

  for (genvar g = 0; g < 3; g++) begin : g_phase
    logic [15:0] ph;
    logic [3:0] idx;
    logic [7:0] samp;
    logic [27:0] prod;
    logic [11:0] mag;
    assign ph = wif.phase_acc + OFS[g];
    assign idx = ph[14] ? ~ph[13:10] : ph[13:10];
    assign samp = wif.third_harm ? THIRD_TBL[idx] : SINE_TBL[idx];
    // Sample scaled to half modulus, then by amplitude
    assign prod = 28'(samp) * 28'(wif.half_mod) * 28'(wif.amplitude);
    assign mag = prod[27:16];
    assign wif.duty[g] = ph[15] ? wif.half_mod - mag : wif.half_mod + mag;
  end
endmodule // tpsp_wave

/* logic/tpsp_top.sv */
`timescale 1ns/1ps
`include "tpsp_regs.svh"
module tpsp_top #(
  parameter int LED_TOGGLE_CYCLES = int'(`TPSP_LED_TOGGLE_CYC),
  parameter int RECOVERY_CYCLES = int'(`TPSP_RECOVERY_CYC),
  parameter int TACHO_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic start_stop_sw,
  input wire logic braking_in,
  input wire logic decel_in,
  input wire logic overcurrent_fault_input,
  input wire logic [9:0] dc_bus_volts,
  input wire logic tacho_in,
  output logic [5:0] motor_drive_outputs,
  output logic fault_led,
  output logic pfc_enable,
  output logic speed_ramp_hold,
  output logic general_fault_flag
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_reg;
  logic rst_n_int;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  tpsp_pkg::tpsp_state_t state_reg, state_next;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic rd_hit;
  logic wr_fire, rd_fire;
  logic [31:0] wmask;
  logic third_reg, errclr_reg;
  logic [15:0] inc_reg;
  logic [7:0] amp_reg;
  logic [2:0] presc_reg;
  logic [11:0] mod_reg;
  logic [9:0] ovlim_reg;
  logic [11:0] pwm_cnt_reg;
  logic [2:0] presc_cnt_reg;
  logic period_end, update;
  logic [15:0] acc_reg;
  logic [11:0] duty_reg [3];
  logic [5:0] motor_reg;
  logic oc_prev_reg, oc_rise;
  logic over, ov_evt, fault_evt;
  logic oc_flag_reg, ov_flag_reg;
  logic seen_stop_reg, clear_req;
  logic [31:0] rec_cnt_reg;
  logic rec_done;
  logic [31:0] led_cnt_reg;
  logic led_reg, pfc_reg, hold_reg;
  logic tacho_prev_reg;
  logic [TACHO_W-1:0] tacho_cnt_reg, tacho_period_reg;

  tpsp_wave_if wif ();

  tpsp_wave u_wave (
    .wif(wif)
  );

  assign wif.phase_acc = acc_reg;
  assign wif.third_harm = third_reg;
  assign wif.amplitude = amp_reg;
  assign wif.half_mod = {1'b0, mod_reg[11:1]};

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  assign wr_fire = s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg;
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TPSP_RESP_OKAY;
    end else begin
      // Address and data taken together, one write at a time
      awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
      wready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        case (s_axi_awaddr)
          `TPSP_ADDR_CTRL, `TPSP_ADDR_INC, `TPSP_ADDR_AMP, `TPSP_ADDR_PRESC, `TPSP_ADDR_MOD,
          `TPSP_ADDR_OVLIM, `TPSP_ADDR_STATUS, `TPSP_ADDR_TACHO, `TPSP_ADDR_DUTY_A,
          `TPSP_ADDR_DUTY_B, `TPSP_ADDR_DUTY_C: bresp_reg <= `TPSP_RESP_OKAY;
          default: bresp_reg <= `TPSP_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `TPSP_RESP_OKAY;
    end else begin
      arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdata_next;
        rresp_reg <= rd_hit ? `TPSP_RESP_OKAY : `TPSP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TPSP_ADDR_CTRL: rdata_next[`TPSP_CTRL_THIRD] = third_reg;
      `TPSP_ADDR_INC: rdata_next[15:0] = inc_reg;
      `TPSP_ADDR_AMP: rdata_next[7:0] = amp_reg;
      `TPSP_ADDR_PRESC: rdata_next[2:0] = presc_reg;
      `TPSP_ADDR_MOD: rdata_next[11:0] = mod_reg;
      `TPSP_ADDR_OVLIM: rdata_next[9:0] = ovlim_reg;
      `TPSP_ADDR_STATUS: begin
        rdata_next[`TPSP_ST_GF] = oc_flag_reg || ov_flag_reg;
        rdata_next[`TPSP_ST_OC] = oc_flag_reg;
        rdata_next[`TPSP_ST_OV] = ov_flag_reg;
        rdata_next[`TPSP_ST_RUN] = (state_reg == tpsp_pkg::TPSP_RUN);
        rdata_next[`TPSP_ST_PFC] = pfc_reg;
        rdata_next[`TPSP_ST_HOLD] = hold_reg;
        rdata_next[9:8] = state_reg;
      end
      `TPSP_ADDR_TACHO: rdata_next[TACHO_W-1:0] = tacho_period_reg;
      `TPSP_ADDR_DUTY_A: rdata_next[11:0] = duty_reg[0];
      `TPSP_ADDR_DUTY_B: rdata_next[11:0] = duty_reg[1];
      `TPSP_ADDR_DUTY_C: rdata_next[11:0] = duty_reg[2];
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      third_reg <= 1'b0;
      errclr_reg <= 1'b0;
      inc_reg <= `TPSP_INC_RST;
      amp_reg <= `TPSP_AMP_RST;
      presc_reg <= `TPSP_PRESC_RST;
      mod_reg <= `TPSP_MODULUS_RST;
      ovlim_reg <= `TPSP_OVLIM_RST;
    end else begin
      errclr_reg <= 1'b0;
      if (wr_fire) begin
        case (s_axi_awaddr)
          `TPSP_ADDR_CTRL: begin
            if (s_axi_wstrb[0]) begin
              third_reg <= s_axi_wdata[`TPSP_CTRL_THIRD];
              errclr_reg <= s_axi_wdata[`TPSP_CTRL_ERRCLR];
            end
          end
          `TPSP_ADDR_INC: inc_reg <= (inc_reg & ~wmask[15:0]) | (s_axi_wdata[15:0] & wmask[15:0]);
          `TPSP_ADDR_AMP: amp_reg <= (amp_reg & ~wmask[7:0]) | (s_axi_wdata[7:0] & wmask[7:0]);
          `TPSP_ADDR_PRESC: presc_reg <= (presc_reg & ~wmask[2:0]) | (s_axi_wdata[2:0] & wmask[2:0]);
          `TPSP_ADDR_MOD: mod_reg <= (mod_reg & ~wmask[11:0]) | (s_axi_wdata[11:0] & wmask[11:0]);
          `TPSP_ADDR_OVLIM: ovlim_reg <= (ovlim_reg & ~wmask[9:0]) | (s_axi_wdata[9:0] & wmask[9:0]);
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM carrier and update rate
  assign period_end = (pwm_cnt_reg >= mod_reg - 12'h1);
  assign update = period_end && ((presc_cnt_reg + 3'h1) >= presc_reg);

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pwm_cnt_reg <= 12'h0;
      presc_cnt_reg <= 3'h0;
    end else begin
      pwm_cnt_reg <= period_end ? 12'h0 : pwm_cnt_reg + 12'h1;
      if (update) begin
        presc_cnt_reg <= 3'h0;
      end else if (period_end) begin
        presc_cnt_reg <= presc_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      acc_reg <= 16'h0;
      duty_reg <= '{12'h0, 12'h0, 12'h0};
    end else if (update) begin
      acc_reg <= acc_reg + inc_reg;
      duty_reg <= wif.duty;
    end
  end

  // Complementary pairs, all low unless running
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      motor_reg <= 6'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (state_next == tpsp_pkg::TPSP_RUN && !overcurrent_fault_input) begin
          motor_reg[2*i] <= (pwm_cnt_reg < duty_reg[i]);
          motor_reg[2*i+1] <= !(pwm_cnt_reg < duty_reg[i]);
        end else begin
          motor_reg[2*i] <= 1'b0;
          motor_reg[2*i+1] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault detection and drive state
  assign oc_rise = overcurrent_fault_input && !oc_prev_reg;
  assign over = (dc_bus_volts > ovlim_reg);
  assign ov_evt = over && braking_in && !pfc_reg && (state_reg == tpsp_pkg::TPSP_RUN);
  assign fault_evt = oc_rise || ov_evt;
  assign clear_req = errclr_reg || (seen_stop_reg && start_stop_sw);
  assign rec_done = (rec_cnt_reg >= 32'(RECOVERY_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tpsp_pkg::TPSP_STOP: begin
        if (oc_rise) begin
          state_next = tpsp_pkg::TPSP_FAULT;
        end else if (start_stop_sw) begin
          state_next = tpsp_pkg::TPSP_RUN;
        end
      end
      tpsp_pkg::TPSP_RUN: begin
        if (fault_evt) begin
          state_next = tpsp_pkg::TPSP_FAULT;
        end else if (!start_stop_sw) begin
          state_next = tpsp_pkg::TPSP_STOP;
        end
      end
      tpsp_pkg::TPSP_FAULT: begin
        if (clear_req && !fault_evt) begin
          state_next = tpsp_pkg::TPSP_RECOVER;
        end
      end
      tpsp_pkg::TPSP_RECOVER: begin
        if (oc_rise) begin
          state_next = tpsp_pkg::TPSP_FAULT;
        end else if (rec_done) begin
          state_next = tpsp_pkg::TPSP_STOP;
        end
      end
      default: state_next = tpsp_pkg::TPSP_STOP;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      state_reg <= tpsp_pkg::TPSP_STOP;
      oc_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      oc_prev_reg <= overcurrent_fault_input;
    end
  end

  // Flags: a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      oc_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
    end else begin
      if (oc_rise) begin
        oc_flag_reg <= 1'b1;
      end else if (state_reg == tpsp_pkg::TPSP_FAULT && clear_req) begin
        oc_flag_reg <= 1'b0;
      end
      if (ov_evt) begin
        ov_flag_reg <= 1'b1;
      end else if (state_reg == tpsp_pkg::TPSP_FAULT && clear_req && !oc_rise) begin
        ov_flag_reg <= 1'b0;
      end
    end
  end

  // Stop position must be seen after the fault
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      seen_stop_reg <= 1'b0;
    end else if (state_reg != tpsp_pkg::TPSP_FAULT || state_next != tpsp_pkg::TPSP_FAULT) begin
      seen_stop_reg <= 1'b0;
    end else if (!start_stop_sw) begin
      seen_stop_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rec_cnt_reg <= 32'h0;
    end else if (state_reg == tpsp_pkg::TPSP_RECOVER) begin
      rec_cnt_reg <= rec_cnt_reg + 32'h1;
    end else begin
      rec_cnt_reg <= 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault indicator, PFC enable, ramp hold
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      led_cnt_reg <= 32'h0;
      led_reg <= 1'b0;
    end else if (oc_flag_reg || ov_flag_reg) begin
      if (led_cnt_reg >= 32'(LED_TOGGLE_CYCLES - 1)) begin
        led_cnt_reg <= 32'h0;
        led_reg <= !led_reg;
      end else begin
        led_cnt_reg <= led_cnt_reg + 32'h1;
      end
    end else begin
      led_cnt_reg <= 32'h0;
      led_reg <= 1'b0;
    end
  end

  // PFC runs with the motor, but not when braking or on motoring overvoltage
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      pfc_reg <= 1'b0;
    end else begin
      pfc_reg <= (state_next == tpsp_pkg::TPSP_RUN) && !braking_in && !over;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      hold_reg <= 1'b0;
    end else if (!decel_in || dc_bus_volts <= ovlim_reg - `TPSP_OV_HYST) begin
      hold_reg <= 1'b0;
    end else if (over) begin
      hold_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tachometer period
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      tacho_prev_reg <= 1'b0;
      tacho_cnt_reg <= '0;
      tacho_period_reg <= '0;
    end else begin
      tacho_prev_reg <= tacho_in;
      if (tacho_in && !tacho_prev_reg) begin
        tacho_period_reg <= tacho_cnt_reg;
        tacho_cnt_reg <= TACHO_W'(1);
      end else if (tacho_cnt_reg != '1) begin
        tacho_cnt_reg <= tacho_cnt_reg + TACHO_W'(1);
      end
    end
  end

  assign motor_drive_outputs = motor_reg;
  assign fault_led = led_reg;
  assign pfc_enable = pfc_reg;
  assign speed_ramp_hold = hold_reg;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      general_fault_flag <= 1'b0;
    end else begin
      general_fault_flag <= (oc_flag_reg || oc_rise) || (ov_flag_reg || ov_evt);
    end
  end

endmodule // tpsp_top

/* verif/tpsp_top_assertions.sv */
`timescale 1ns/1ps
`include "tpsp_regs.svh"
module tpsp_top_assertions #(
  parameter int LED_TOGGLE_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_stop_sw,
  input wire logic braking_in,
  input wire logic decel_in,
  input wire logic overcurrent_fault_input,
  input wire logic [9:0] dc_bus_volts,
  input wire logic [5:0] motor_drive_outputs,
  input wire logic fault_led,
  input wire logic pfc_enable,
  input wire logic speed_ramp_hold,
  input wire logic general_fault_flag
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic over_lim;
  logic led_q;
  int led_cnt;
  assign over_lim = dc_bus_volts > `TPSP_OVLIM_RST;
  // Cycles the lamp has held its level during a fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= 1'b0;
      led_cnt <= 0;
    end else begin
      led_q <= fault_led;
      led_cnt <= (general_fault_flag && fault_led == led_q) ? led_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_oc_drive_off: assert property ($rose(overcurrent_fault_input) |=> motor_drive_outputs == 6'h00)
    else $error("drive still active after overcurrent");
  a_oc_flag_set: assert property ($rose(overcurrent_fault_input) |-> ##[1:3] general_fault_flag)
    else $error("fault flag missing after overcurrent");
  a_fault_drive_off: assert property (general_fault_flag && $past(general_fault_flag) |-> !motor_drive_outputs)
    else $error("drive active during fault");
  a_led_dark: assert property (!general_fault_flag [*2] |-> !fault_led)
    else $error("fault lamp lit without fault");
  a_led_slow: assert property (led_cnt <= LED_TOGGLE_CYCLES + 1)
    else $error("fault lamp not flashing");
  a_led_fast: assert property ($fell(fault_led) && general_fault_flag |-> led_cnt >= LED_TOGGLE_CYCLES - 1)
    else $error("fault lamp flashing too fast");
  a_pfc_brake_off: assert property (braking_in [*2] |=> !pfc_enable)
    else $error("pfc on while braking");
  a_pfc_stop_off: assert property (!start_stop_sw [*3] |=> !pfc_enable)
    else $error("pfc on while stopped");
  a_hold_set: assert property ((decel_in && over_lim) [*2] |=> speed_ramp_hold)
    else $error("ramp not held on overvoltage");
  a_hold_clear: assert property (!decel_in [*2] |=> !speed_ramp_hold)
    else $error("ramp held without deceleration");
  a_motor_no_fault: assert property ((!braking_in && !overcurrent_fault_input && !general_fault_flag) [*3] |=> !general_fault_flag)
    else $error("fault raised while motoring");
  c_fault: cover property ($rose(general_fault_flag));
  c_flash: cover property ($fell(fault_led) && general_fault_flag);
  c_hold: cover property ($rose(speed_ramp_hold));
endmodule // tpsp_top_assertions

/* verif/tpsp_stage_model.sv */
`timescale 1ns/1ps
module tpsp_stage_model (
  input wire logic clk,
  input wire logic [5:0] drive,
  input wire logic trip_cmd,
  input wire logic [9:0] volts_cmd,
  input wire logic [15:0] tacho_cyc,
  output logic overcurrent_fault_input,
  output logic [9:0] dc_bus_volts,
  output logic tacho_in
);
  int cnt = 0;
  initial begin
    overcurrent_fault_input = 1'b0;
    dc_bus_volts = 10'd300;
    tacho_in = 1'b0;
  end
  // Shoot-through on any leg trips the current sense
  always @(posedge clk) begin
    overcurrent_fault_input <= trip_cmd || (|(drive & (drive >> 1) & 6'h15));
    dc_bus_volts <= volts_cmd;
    cnt <= (cnt + 1 >= int'(tacho_cyc)) ? 0 : cnt + 1;
    tacho_in <= (cnt == 0);
  end
endmodule // tpsp_stage_model

/* verif/test_three_phase_sine_pwm_fault.sv */
`timescale 1ns/1ps
`include "tpsp_regs.svh"
module test_three_phase_sine_pwm_fault;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic start_stop_sw = 1'b0;
  logic braking_in = 1'b0;
  logic decel_in = 1'b0;
  logic overcurrent_fault_input;
  logic [9:0] dc_bus_volts;
  logic tacho_in;
  logic [5:0] motor_drive_outputs;
  logic fault_led;
  logic pfc_enable;
  logic speed_ramp_hold;
  logic general_fault_flag;
  logic trip_cmd = 1'b0;
  logic [9:0] volts_cmd = 10'd300;
  logic [15:0] tacho_cyc;
  logic [31:0] seed = 32'hb6ad;
  logic [31:0] d;
  logic [1:0] r;
  logic [31:0] rst_tab [6] = '{32'h0, 32'h0, 32'h4, 32'h61a, 32'h190, 32'h0};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  tpsp_top #(.LED_TOGGLE_CYCLES(8), .RECOVERY_CYCLES(8), .TACHO_W(24)) dut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .start_stop_sw, .braking_in, .decel_in, .overcurrent_fault_input, .dc_bus_volts, .tacho_in,
    .motor_drive_outputs, .fault_led, .pfc_enable, .speed_ramp_hold, .general_fault_flag);

  tpsp_stage_model stage (.clk, .drive(motor_drive_outputs), .trip_cmd, .volts_cmd, .tacho_cyc,
    .overcurrent_fault_input, .dc_bus_volts, .tacho_in);

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] st_exp(input logic [1:0] st, input logic [2:0] fl);
    return {22'h0, st, 5'h00, fl};
  endfunction

  task stop_test();
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(d & m, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_total++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int tc;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] last;
    tacho_cyc = 16'(rnd() % 100 + 40);
    wait_cyc(5);
    rst_n <= 1'b1;
    wait_cyc(3);
    for (int i = 0; i < 6; i++) rdc(8'h04 + 8'(4 * i), 32'hffffffff, rst_tab[i]);
    axw(`TPSP_ADDR_MOD, 32'd64);
    axw(8'h40, 32'h1);
    chk({30'h0, r}, 32'h2);
    axr(8'h40);
    chk({d[31:2], r}, 32'h2);
    axw(`TPSP_ADDR_STATUS, 32'hff);
    rdc(`TPSP_ADDR_STATUS, 32'h3f, 32'h0);
    start_stop_sw <= 1'b1;
    // Zero phase: A at mid scale, B and C mirror about it
    for (int t = 0; t < 2; t++) begin
      axw(`TPSP_ADDR_CTRL, 32'(t));
      axw(`TPSP_ADDR_AMP, {24'h0, 8'(rnd() % 83 + 10)});
      wait_cyc(600);
      rdc(`TPSP_ADDR_DUTY_A, 32'hfff, 32'd32);
      axr(`TPSP_ADDR_DUTY_B);
      lo = d;
      axr(`TPSP_ADDR_DUTY_C);
      chk(lo + d, 32'd64);
      chk({31'h0, lo > 32 && lo < 64}, 32'h1);
    end
    chk({31'h0, pfc_enable}, 32'h1);
    n = int'(rnd() % 4) + 1;
    axw(`TPSP_ADDR_PRESC, 32'(n));
    axr(`TPSP_ADDR_DUTY_A);
    last = d;
    axw(`TPSP_ADDR_INC, 32'h4000);
    lo = 32'hfff;
    hi = 32'h0;
    tc = 0;
    repeat (600) begin
      axr(`TPSP_ADDR_DUTY_A);
      if (d !== last) begin
        if (tc != 0) chk({31'h0, $unsigned(cyc - tc - n * 64 + 4) <= 8}, 32'h1);
        tc = cyc;
        last = d;
      end
      if (d > hi) hi = d;
      if (d < lo) lo = d;
    end
    chk(hi + lo, 32'd64);
    chk({31'h0, hi > 32}, 32'h1);
    trip_cmd <= 1'b1;
    wait_cyc(4);
    chk({26'h0, motor_drive_outputs}, 32'h0);
    trip_cmd <= 1'b0;
    rdc(`TPSP_ADDR_STATUS, 32'h7, 32'h3);
    wait_cyc(40);
    chk({31'h0, general_fault_flag}, 32'h1);
    axw(`TPSP_ADDR_CTRL, 32'h2);
    chk({26'h0, motor_drive_outputs}, 32'h0);
    wait_cyc(30);
    rdc(`TPSP_ADDR_STATUS, 32'h307, st_exp(2'h1, 3'h0));
    volts_cmd <= 10'd450;
    wait_cyc(6);
    chk({30'h0, pfc_enable, general_fault_flag}, 32'h0);
    rdc(`TPSP_ADDR_STATUS, 32'h307, st_exp(2'h1, 3'h0));
    decel_in <= 1'b1;
    wait_cyc(4);
    chk({31'h0, speed_ramp_hold}, 32'h1);
    volts_cmd <= 10'd390;
    wait_cyc(4);
    chk({31'h0, speed_ramp_hold}, 32'h1);
    volts_cmd <= 10'd370;
    wait_cyc(4);
    chk({31'h0, speed_ramp_hold}, 32'h0);
    decel_in <= 1'b0;
    braking_in <= 1'b1;
    wait_cyc(4);
    volts_cmd <= 10'd401;
    wait_cyc(6);
    rdc(`TPSP_ADDR_STATUS, 32'h307, st_exp(2'h2, 3'h5));
    chk({26'h0, motor_drive_outputs}, 32'h0);
    volts_cmd <= 10'd300;
    braking_in <= 1'b0;
    start_stop_sw <= 1'b0;
    wait_cyc(6);
    start_stop_sw <= 1'b1;
    wait_cyc(30);
    rdc(`TPSP_ADDR_STATUS, 32'h307, st_exp(2'h1, 3'h0));
    rdc(`TPSP_ADDR_TACHO, 32'hffffff, {16'h0, tacho_cyc});
    stop_test();
  end
endmodule // test_three_phase_sine_pwm_fault

bind tpsp_top tpsp_top_assertions #(.LED_TOGGLE_CYCLES(LED_TOGGLE_CYCLES)) chk_i (
  .clk, .rst_n, .start_stop_sw, .braking_in, .decel_in, .overcurrent_fault_input, .dc_bus_volts,
  .motor_drive_outputs, .fault_led, .pfc_enable, .speed_ramp_hold, .general_fault_flag);
